// file: inc/scp_pkg.sv
// shared constants and types for the serial control port slave
package scp_pkg;

  // I2C slave address: fixed upper bits, two strap bits below
  localparam logic [4:0]  SLV_ADDR_FIXED  = 5'h15;
  localparam int          SLV_ADDR_W      = 7;
  localparam int          BYTE_BITS       = 8;
  localparam logic [3:0]  BYTE_BITS_CNT   = 4'h8;
  localparam int          DATA_W          = 8;
  localparam int          REG_ADDR_W      = 16;
  localparam int          FIFO_DEPTH      = 4;
  localparam int          WR_WORD_W       = REG_ADDR_W + DATA_W;

  // serial instruction word: direction bit on top, start address below
  localparam int          INSTR_W         = 16;
  localparam int          INSTR_RW_BIT    = 15;
  localparam int          INSTR_ADDR_W    = 15;
  localparam logic [15:0] STEP_ADDR_TOP   = 16'h1fff;
  localparam logic [15:0] STEP_ADDR_BOT   = 16'h0000;

  // address stepping control: both set steps up, both clear steps down
  localparam logic [1:0]  STEP_UP         = 2'h3;
  localparam logic [1:0]  STEP_DOWN       = 2'h0;

  // reset values
  localparam logic [15:0] RST_PTR         = 16'h0000;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [6:0]  RST_SLV_ADDR    = 7'h00;

  // timing: straps settle through the synchroniser before capture
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;
  localparam int          REF_CLK_KHZ     = 125000;
  localparam int          SCL_STD_KHZ     = 100;
  localparam int          SCL_FAST_KHZ    = 400;
  localparam int          SCL_FAST_CYC    = REF_CLK_KHZ / SCL_FAST_KHZ;
  localparam int          SCL_STD_CYC     = REF_CLK_KHZ / SCL_STD_KHZ;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_RX,
    ST_ACK_RX,
    ST_TX,
    ST_ACK_TX,
    ST_WAIT
  } scp_state_t;

endpackage

// file: core/scp_fifo.sv
// small synchronous fifo for register write words
`timescale 1ns/1ps
module scp_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  output logic [W-1:0]      o_out_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          valid_q;
  logic [W-1:0]  head_q;
  wire           push = i_in_valid & o_in_ready;
  wire           pop  = valid_q & i_out_ready;
  wire [AW-1:0]  rd_n = !pop ? rd_q : (rd_q == LAST) ? '0 : rd_q + 1'b1;
  wire [AW:0]    left = cnt_q - (AW+1)'(pop);
  wire [AW:0]    cnt_n = left + (AW+1)'(push);
  // head word is kept in a flop so the outputs need no read mux
  wire [W-1:0]   head_n = (left == '0) ? i_in_data : mem_q[rd_n];

  assign o_in_ready  = (cnt_q != FULL_CNT);
  assign o_out_valid = valid_q;
  assign o_out_data  = head_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      valid_q <= 1'b0;
      head_q  <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      rd_q    <= rd_n;
      cnt_q   <= cnt_n;
      valid_q <= (cnt_n != '0);
      head_q  <= head_n;
    end
  end

  // storage needs no reset: a word is only read after it was written
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
endmodule

// file: core/scp_i2c_slave.sv
// I2C register slave sampled on the reference clock, with write fifo
`timescale 1ns/1ps
// Contract
// - both step bits clear: address steps down
// - both step bits set: address steps up
// - no address skipped in multibyte transfers
// - instruction word: direction bit, fifteen address bits (code: direction bit ends the address byte, two bytes set a 16-bit pointer)
// - works at standard and fast SCL rates
// - slave only, never drives SCL
// - answer only to matching seven-bit address
// - address fixed high bits plus strap pins
// - SDA fall with SCL high starts transaction
// - SDA rise with SCL high ends transaction
// - eight bits MSB first, then ack bit
// - receiver pulls SDA low on ninth pulse
// - not acknowledged after sent byte: go idle
// - first byte is address plus direction bit
// - two write bytes set register address, high first
// - following write bytes are register data
// - read slots carry register data
// - unlimited bytes, end only at stop/start/nack
// - start or stop anywhere drops partial byte
module scp_i2c_slave
  import scp_pkg::*;
#(
  parameter int FIFO_W = scp_pkg::WR_WORD_W,
  parameter int FIFO_D = scp_pkg::FIFO_DEPTH
) (
  input  wire logic                          I_REF_CLK,
  input  wire logic                          I_RSTN,
  input  wire logic                          I_SCL,
  input  wire logic                          I_SDA_IN,
  output logic                               O_SDA_OUT,
  output logic                               O_SDA_OE,
  input  wire logic                          I_PORT_SELECT_PIN_LOW,
  input  wire logic                          I_PORT_SELECT_PIN_HIGH,
  input  wire logic [1:0]                    I_ADDR_STEP_CTRL,
  output logic                               O_WR_VALID,
  output logic [scp_pkg::REG_ADDR_W-1:0]     O_WR_ADDR,
  output logic [scp_pkg::DATA_W-1:0]         O_WR_DATA,
  input  wire logic                          I_WR_READY,
  output logic                               O_RD_REQ,
  output logic [scp_pkg::REG_ADDR_W-1:0]     O_RD_ADDR,
  input  wire logic [scp_pkg::DATA_W-1:0]    I_RD_DATA,
  output logic                               O_BUSY
);
  import scp_pkg::*;

  // no stepping mode skips an address; mixed control bits step up
  function automatic logic [REG_ADDR_W-1:0] step_addr(
    input logic [REG_ADDR_W-1:0] a,
    input logic [1:0]            ctrl
  );
    if (ctrl == STEP_DOWN) begin
      step_addr = a - 1'b1;
    end else begin
      step_addr = a + 1'b1;
    end
  endfunction

  // the sampled SCL must show both levels several times per bit
  localparam int MIN_SCL_CYC = 8;
  if (SCL_FAST_CYC < MIN_SCL_CYC || SCL_STD_CYC < SCL_FAST_CYC) begin : g_rate
    $error("reference clock too slow for fast mode SCL");
  end

  // two-flop synchronisers, plus a third flop on SCL and SDA for edge detection
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic spl_m_q, spl_s_q, sph_m_q, sph_s_q;
  logic [1:0] strap_cnt_q;
  logic [SLV_ADDR_W-1:0] own_addr_q;

  // protocol state
  scp_state_t state_q, state_d;
  logic [3:0]            cnt_q, cnt_d;
  logic [BYTE_BITS-1:0]  sh_q, sh_d;
  logic                  rw_q, rw_d;
  logic [1:0]            phase_q, phase_d;
  logic [REG_ADDR_W-1:0] ptr_q, ptr_d;
  logic                  oe_q, oe_d;
  logic                  rd_req_q, rd_req_d;
  logic [REG_ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic                  rd_pend_q;
  logic [DATA_W-1:0]     tx_q, tx_d;
  logic                  push_q, push_d;
  logic [FIFO_W-1:0]     push_word_q, push_word_d;
  logic                  busy_q;
  logic                  sda_out_q;

  wire scl_rise   = scl_s_q & ~scl_p_q;
  wire scl_fall   = ~scl_s_q & scl_p_q;
  wire scl_high   = scl_s_q & scl_p_q;
  wire start_det  = scl_high & sda_p_q & ~sda_s_q;
  wire stop_det   = scl_high & ~sda_p_q & sda_s_q;
  wire byte_full  = (cnt_q == BYTE_BITS_CNT);
  wire addr_match = (sh_q[7:1] == own_addr_q);
  wire strap_done = (strap_cnt_q == STRAP_SETTLE);

  logic                  fifo_in_ready;
  logic [FIFO_W-1:0]     fifo_out_data;
  logic                  fifo_out_valid;
  wire                   fifo_room = fifo_in_ready & ~push_q;

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    sh_d        = sh_q;
    rw_d        = rw_q;
    phase_d     = phase_q;
    ptr_d       = ptr_q;
    oe_d        = oe_q;
    rd_req_d    = 1'b0;
    rd_addr_d   = rd_addr_q;
    tx_d        = rd_pend_q ? I_RD_DATA : tx_q;
    push_d      = 1'b0;
    push_word_d = push_word_q;
    if (start_det) begin
      // repeated start also lands here; a partial byte is dropped
      state_d = ST_ADDR;
      cnt_d   = '0;
      phase_d = '0;
      oe_d    = 1'b0;
    end else if (stop_det) begin
      state_d = ST_IDLE;
      cnt_d   = '0;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise && !byte_full) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 1'b1;
          end
          if (scl_fall && byte_full) begin
            cnt_d = '0;
            if (state_q == ST_ADDR) begin
              if (addr_match) begin
                rw_d    = sh_q[0];
                state_d = ST_ACK_ADDR;
                oe_d    = 1'b1;
                if (sh_q[0]) begin
                  rd_req_d  = 1'b1;
                  rd_addr_d = ptr_q;
                  ptr_d     = step_addr(ptr_q, I_ADDR_STEP_CTRL);
                end
              end else begin
                state_d = ST_WAIT;
              end
            end else if (phase_q == 2'h0) begin
              ptr_d[15:8] = sh_q;
              phase_d     = 2'h1;
              state_d     = ST_ACK_RX;
              oe_d        = 1'b1;
            end else if (phase_q == 2'h1) begin
              ptr_d[7:0] = sh_q;
              phase_d    = 2'h2;
              state_d    = ST_ACK_RX;
              oe_d       = 1'b1;
            end else if (fifo_room) begin
              push_d      = 1'b1;
              push_word_d = {ptr_q, sh_q};
              ptr_d       = step_addr(ptr_q, I_ADDR_STEP_CTRL);
              state_d     = ST_ACK_RX;
              oe_d        = 1'b1;
            end else begin
              // full buffer: leave SDA high so the host sees a nack
              state_d = ST_WAIT;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_RX: begin
          if (scl_fall) begin
            cnt_d = '0;
            if (rw_q) begin
              state_d = ST_TX;
              sh_d    = tx_q;
              oe_d    = ~tx_q[7];
            end else begin
              state_d = ST_RX;
              oe_d    = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 1'b1;
          end
          if (scl_fall) begin
            if (byte_full) begin
              state_d = ST_ACK_TX;
              cnt_d   = '0;
              oe_d    = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            if (sda_s_q) begin
              state_d = ST_WAIT;
            end else begin
              rd_req_d  = 1'b1;
              rd_addr_d = ptr_q;
              ptr_d     = step_addr(ptr_q, I_ADDR_STEP_CTRL);
            end
          end else if (scl_fall) begin
            state_d = ST_TX;
            sh_d    = tx_q;
            oe_d    = ~tx_q[7];
          end
        end
        ST_IDLE, ST_WAIT: begin
          oe_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {spl_m_q, spl_s_q, sph_m_q, sph_s_q} <= 4'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {I_SCL, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {I_SDA_IN, sda_m_q, sda_s_q};
      {spl_m_q, spl_s_q} <= {I_PORT_SELECT_PIN_LOW, spl_m_q};
      {sph_m_q, sph_s_q} <= {I_PORT_SELECT_PIN_HIGH, sph_m_q};
    end
  end

  // straps are loaded on each cycle until the synchroniser has settled, then held
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      strap_cnt_q <= '0;
      own_addr_q  <= RST_SLV_ADDR;
    end else if (!strap_done) begin
      strap_cnt_q <= strap_cnt_q + 1'b1;
      // low strap high clears bit 1, high strap sets bit 0
      own_addr_q  <= {SLV_ADDR_FIXED, ~spl_s_q, sph_s_q};
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q     <= ST_IDLE;
      cnt_q       <= '0;
      sh_q        <= RST_BYTE;
      rw_q        <= 1'b0;
      phase_q     <= '0;
      ptr_q       <= RST_PTR;
      oe_q        <= 1'b0;
      rd_req_q    <= 1'b0;
      rd_addr_q   <= RST_PTR;
      rd_pend_q   <= 1'b0;
      tx_q        <= RST_BYTE;
      push_q      <= 1'b0;
      push_word_q <= '0;
      busy_q      <= 1'b0;
      sda_out_q   <= 1'b0;
    end else begin
      state_q     <= strap_done ? state_d : ST_IDLE;
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      rw_q        <= rw_d;
      phase_q     <= phase_d;
      ptr_q       <= ptr_d;
      oe_q        <= oe_d;
      rd_req_q    <= rd_req_d;
      rd_addr_q   <= rd_addr_d;
      rd_pend_q   <= rd_req_q;
      tx_q        <= tx_d;
      push_q      <= push_d;
      push_word_q <= push_word_d;
      busy_q      <= (state_d != ST_IDLE) && (state_d != ST_WAIT);
      sda_out_q   <= 1'b0;
    end
  end

  // open drain: SDA is only ever pulled low, SCL has no output at all
  assign O_SDA_OUT = sda_out_q;
  assign O_SDA_OE  = oe_q;
  assign O_RD_REQ  = rd_req_q;
  assign O_RD_ADDR = rd_addr_q;
  assign O_BUSY    = busy_q;

  scp_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_clk       (I_REF_CLK),
    .i_rstn      (I_RSTN),
    .i_in_data   (push_word_q),
    .i_in_valid  (push_q),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (fifo_out_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (I_WR_READY)
  );

  assign O_WR_VALID = fifo_out_valid;
  assign O_WR_ADDR  = fifo_out_data[FIFO_W-1:DATA_W];
  assign O_WR_DATA  = fifo_out_data[DATA_W-1:0];

  sequence s_addr_byte_done;
    (state_q == ST_ADDR) && byte_full && scl_fall && !start_det && !stop_det;
  endsequence

  sequence s_nack_seen;
    (state_q == ST_ACK_TX) && scl_rise && sda_s_q && !start_det
      && !stop_det;
  endsequence

  AST_START_OPENS: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) start_det && strap_done
      |=> state_q == ST_ADDR && cnt_q == 4'h0 && !oe_q)
    else $error("start did not open address phase");

  AST_STOP_CLOSES: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) stop_det && !start_det
      |=> state_q == ST_IDLE && !oe_q ##1 !O_BUSY)
    else $error("stop did not return to idle");

  AST_MISMATCH_SILENT: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) s_addr_byte_done and (!addr_match)
      |=> state_q == ST_WAIT && !oe_q)
    else $error("slave answered a foreign address");

  AST_ADDR_ACK: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) s_addr_byte_done and addr_match
      |=> oe_q && state_q == ST_ACK_ADDR)
    else $error("matching address not acknowledged");

  AST_NACK_IDLE: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) s_nack_seen |=> state_q == ST_WAIT
      ##1 !oe_q && !rd_req_q)
    else $error("slave kept sending after nack");

  AST_PUSH_IS_DATA: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) push_d |-> !rw_q && phase_q == 2'h2
      && state_q == ST_RX)
    else $error("address byte pushed as data");

  AST_PTR_STEP: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) push_d && I_ADDR_STEP_CTRL == STEP_UP
      |=> ptr_q == $past(ptr_q) + 16'h0001 && push_q)
    else $error("pointer did not advance after data byte");

  AST_PTR_DOWN: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) push_d && I_ADDR_STEP_CTRL == STEP_DOWN
      |=> ptr_q == $past(ptr_q) - 16'h0001)
    else $error("pointer did not step down");

  AST_RD_PULSE: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) rd_req_q |-> rw_q ##1 !rd_req_q ##1
      tx_q == $past(I_RD_DATA))
    else $error("read request malformed");

  AST_BYTE_BITS: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RSTN) (state_q == ST_TX) && scl_fall && byte_full
      && !start_det && !stop_det |=> state_q == ST_ACK_TX && !oe_q)
    else $error("sent byte not released after eight bits");
endmodule

// file: bench/scp_host_model.sv
// behavioural I2C bus master that drives the slave's SCL and SDA pins
`timescale 1ns/1ps
module scp_host_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // half of the SCL period in ns, changed by the bench for slow runs
  int half = 32;

  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // SDA only moves in the middle of the low phase, SCL stays still between
  task automatic put_bit(input logic b, output logic s);
    #(half/2) o_sda_low = ~b;
    #(half/2) o_scl = 1'b1;
    #(half/2) s = i_sda;
    #(half/2) o_scl = 1'b0;
  endtask

  task automatic start();
    #(half/2) o_sda_low = 1'b0;
    #(half/2) o_scl = 1'b1;
    #(half) o_sda_low = 1'b1;
    #(half) o_scl = 1'b0;
  endtask

  task automatic stop();
    #(half/2) o_sda_low = 1'b1;
    #(half/2) o_scl = 1'b1;
    #(half) o_sda_low = 1'b0;
    #(half);
  endtask

  // n below 8 leaves a partial byte on the bus, with no ack slot
  task automatic send(input logic [7:0] d, input int n, output logic a);
    logic s;
    a = 1'b0;
    for (int i = 0; i < n; i++) begin
      put_bit(d[7-i], s);
    end
    if (n == 8) begin
      put_bit(1'b1, s);
      a = ~s;
    end
  endtask

  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      put_bit(1'b1, s);
      d = {d[6:0], s};
    end
    put_bit(~ack, s);
  endtask
endmodule

// file: bench/testbench.sv
// self-checking bench for the I2C register slave and its write fifo
`timescale 1ns/1ps
module testbench;
  import scp_pkg::*;
  typedef struct {
    logic [6:0]  slv;
    logic [15:0] ptr;
    int          n;
    logic        ok;
    logic [1:0]  step;
  } scp_row_t;

  logic        clk, rstn, scl, host_low, wr_ready, ack, last_ack;
  logic        sda_out, sda_oe, wr_valid, rd_req, busy;
  logic [1:0]  step;
  logic        strap_lo, strap_hi;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data, rx;
  logic [23:0] got_q[$];
  int          num_errors, tests_run, cycles;
  // open-drain wire with pull-up
  wire         sda = (host_low | sda_oe) ? 1'b0 : 1'b1;

  scp_row_t rows [6] = '{
    '{7'h55, 16'h1234, 1, 1'b1, 2'h3},
    '{7'h55, 16'h1ffe, 3, 1'b1, 2'h3},
    '{7'h55, 16'h0001, 3, 1'b1, 2'h0},
    '{7'h54, 16'h0000, 1, 1'b0, 2'h3},
    '{7'h15, 16'h0000, 1, 1'b0, 2'h3},
    '{7'h35, 16'h0000, 1, 1'b0, 2'h3}};

  scp_i2c_slave scp_i2c_slave_inst (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_SCL(scl), .I_SDA_IN(sda),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe),
    .I_PORT_SELECT_PIN_LOW(strap_lo), .I_PORT_SELECT_PIN_HIGH(strap_hi),
    .I_ADDR_STEP_CTRL(step), .O_WR_VALID(wr_valid), .O_WR_ADDR(wr_addr),
    .O_WR_DATA(wr_data), .I_WR_READY(wr_ready), .O_RD_REQ(rd_req),
    .O_RD_ADDR(rd_addr), .I_RD_DATA(rd_data), .O_BUSY(busy));

  scp_host_model scp_host_model_inst (
    .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // register file side: read data follows the request by one cycle
  always @(posedge clk) begin
    cycles++;
    if (rd_req) rd_data <= #1 rd_addr[7:0] ^ 8'h5a;
    if (wr_valid & wr_ready) got_q.push_back({wr_addr, wr_data});
    if (cycles == 50000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic write_regs(input logic [6:0] slv, input logic [15:0] ptr,
                            input int n, output logic a);
    logic k;
    scp_host_model_inst.start();
    scp_host_model_inst.send({slv, 1'b0}, 8, a);
    if (a) begin
      scp_host_model_inst.send(ptr[15:8], 8, k);
      scp_host_model_inst.send(ptr[7:0], 8, k);
      for (int i = 0; i < n; i++) begin
        scp_host_model_inst.send(8'hc0 + 8'(i), 8, last_ack);
      end
    end
    scp_host_model_inst.stop();
    wait_cyc(10);
  endtask

  // writes land at consecutive addresses in the step direction, none skipped
  task automatic expect_words(input logic [15:0] ptr, input int n,
                              input logic up);
    logic [15:0] a;
    chk(24'(got_q.size()), 24'(n));
    for (int i = 0; i < n && got_q.size() > 0; i++) begin
      a = up ? ptr + 16'(i) : ptr - 16'(i);
      chk(got_q.pop_front(), {a, 8'hc0 + 8'(i)});
    end
    got_q.delete();
  endtask

  initial begin
    rstn     = 1'b0;
    strap_lo = 1'b1;
    strap_hi = 1'b1;
    step     = 2'h3;
    wr_ready = 1'b1;
    rd_data  = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    chk({19'h0, sda_oe, sda_out, wr_valid, rd_req, busy}, 24'h0);
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    wait_cyc(10);
    $display("test reset done");

    foreach (rows[i]) begin
      step = rows[i].step;
      write_regs(rows[i].slv, rows[i].ptr, rows[i].n, ack);
      chk({23'h0, ack}, {23'h0, rows[i].ok});
      chk({23'h0, busy}, 24'h0);
      expect_words(rows[i].ptr, rows[i].ok ? rows[i].n : 0, step != 2'h0);
    end
    $display("test table done");

    // repeated start turns the write into a read from the new pointer
    scp_host_model_inst.start();
    scp_host_model_inst.send({7'h55, 1'b0}, 8, ack);
    scp_host_model_inst.send(8'h00, 8, ack);
    scp_host_model_inst.send(8'hfe, 8, ack);
    scp_host_model_inst.start();
    scp_host_model_inst.send({7'h55, 1'b1}, 8, ack);
    chk({23'h0, ack}, 24'h1);
    for (int i = 0; i < 3; i++) begin
      scp_host_model_inst.recv(i < 2, rx);
      chk({16'h0, rx}, {16'h0, (8'hfe + 8'(i)) ^ 8'h5a});
    end
    // after the nack the next byte must not be driven
    wait_cyc(8);
    chk({22'h0, sda_oe, busy}, 24'h0);
    scp_host_model_inst.stop();
    wait_cyc(10);
    $display("test read done");

    // partial byte cut short by a repeated start or by a stop is dropped
    scp_host_model_inst.start();
    scp_host_model_inst.send({7'h55, 1'b0}, 8, ack);
    scp_host_model_inst.send(8'h00, 8, ack);
    scp_host_model_inst.send(8'h20, 8, ack);
    scp_host_model_inst.send(8'h99, 5, ack);
    write_regs(7'h55, 16'h0030, 1, ack);
    expect_words(16'h0030, 1, 1'b1);
    scp_host_model_inst.start();
    scp_host_model_inst.send({7'h55, 1'b0}, 8, ack);
    scp_host_model_inst.send(8'h01, 3, ack);
    scp_host_model_inst.stop();
    wait_cyc(10);
    expect_words(16'h0000, 0, 1'b1);
    $display("test abort done");

    // stalled sink: fifo fills, fifth byte refused, then drains
    wait_cyc(1);
    wr_ready = 1'b0;
    write_regs(7'h55, 16'h0040, 5, ack);
    chk({23'h0, last_ack}, 24'h0);
    chk({23'h0, wr_valid}, 24'h1);
    wr_ready = 1'b1;
    wait_cyc(8);
    expect_words(16'h0040, 4, 1'b1);
    $display("test fifo done");

    // fast-mode bit rate, 400 kHz
    scp_host_model_inst.half = 1250;
    write_regs(7'h55, 16'h0500, 2, ack);
    chk({23'h0, ack}, 24'h1);
    expect_words(16'h0500, 2, 1'b1);
    $display("test slow clock done");

    // second reset with only the low strap set: address becomes 0x54
    scp_host_model_inst.half = 32;
    strap_hi = 1'b0;
    rstn     = 1'b0;
    wait_cyc(2);
    chk({19'h0, sda_oe, sda_out, wr_valid, rd_req, busy}, 24'h0);
    rstn = 1'b1;
    wait_cyc(10);
    write_regs(7'h55, 16'h0000, 1, ack);
    chk({23'h0, ack}, 24'h0);
    write_regs(7'h54, 16'h0600, 1, ack);
    chk({23'h0, ack}, 24'h1);
    expect_words(16'h0600, 1, 1'b1);
    $display("test strap reset done");
    end_sim();
  end
endmodule
